// File: common/hpp_pkg.sv
// Shared constants and types of the host parallel port handshake block
package hpp_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;

  // ****************************************************************
  // Register select codes and half-word identifier
  // ****************************************************************
  localparam logic [1:0] SEL_CTRL     = 2'h0;  // Control register
  localparam logic [1:0] SEL_ADDR     = 2'h1;  // Address register
  localparam logic [1:0] SEL_DATA_INC = 2'h2;  // Data, auto-increment
  localparam logic [1:0] SEL_DATA_FIX = 2'h3;  // Data, fixed address
  localparam logic       HALF_FIRST   = 1'b0;  // First half-word (low)
  localparam logic       DIR_READ     = 1'b1;  // Read/write level: read

  // ****************************************************************
  // Reset values and address step
  // ****************************************************************
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;

  // ****************************************************************
  // Timing: read data lead before ready falls
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int DATA_LEAD_NS  = 100;   // Two CPU clock periods
  localparam int DATA_LEAD_CYC = (DATA_LEAD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 DATA_LEAD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] LEAD_LAST = 3'(DATA_LEAD_CYC);

  // ****************************************************************
  // Internal sequencer states, Gray coded from idle through fetch to lead
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FETCH  = 2'b01,
    ST_LEAD   = 2'b11,
    ST_FINISH = 2'b10
  } hpp_state_t;

endpackage

// File: common/hpp_stream_if.sv
// Valid/ready word stream between the port logic and its write FIFO
`timescale 1ns/1ps
`default_nettype none
interface hpp_stream_if #(parameter int W = 64);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/hpp_fifo.sv
// Write FIFO with registered read data and honest full/empty
`timescale 1ns/1ps
`default_nettype none
module hpp_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Filling and draining sides
  hpp_stream_if.snk in_s,
  hpp_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_r, wptr_nxt;
  logic [AW-1:0] rptr_r, rptr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic [W-1:0]  out_data_r, out_data_nxt;
  logic          out_valid_r, out_valid_nxt;
  logic          push;
  logic          load;

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  assign in_s.ready  = (count_r != CW'(DEPTH));  // Full stalls the source
  assign out_s.valid = out_valid_r;
  assign out_s.data  = out_data_r;
  assign push = in_s.valid & in_s.ready;
  assign load = (count_r != '0) & (~out_valid_r | out_s.ready);

  // Pointer, count and output register next values
  always_comb begin
    wptr_nxt      = wptr_r;
    rptr_nxt      = rptr_r;
    count_nxt     = count_r;
    out_data_nxt  = out_data_r;
    out_valid_nxt = out_valid_r;
    if (out_s.ready) begin
      out_valid_nxt = 1'b0;
    end
    if (push) begin
      wptr_nxt = (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
    end
    if (load) begin
      rptr_nxt      = (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      out_data_nxt  = mem[rptr_r];
      out_valid_nxt = 1'b1;
    end
    if (push && !load) begin
      count_nxt = count_r + 1'b1;
    end else if (load && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Register state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wptr_r      <= '0;
      rptr_r      <= '0;
      count_r     <= '0;
      out_data_r  <= '0;
      out_valid_r <= 1'b0;
    end else begin
      wptr_r      <= wptr_nxt;
      rptr_r      <= rptr_nxt;
      count_r     <= count_nxt;
      out_data_r  <= out_data_nxt;
      out_valid_r <= out_valid_nxt;
    end
  end

  // Storage array, written on accepted pushes
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_r] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// File: core/hpp_port.sv
// Host parallel port handshake: strobe, select capture, ready, data bus
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Strobe low when data strobes differ, select low
// - Ready held low while chip select high
// - Ready high at select if still completing
// - Data read first half fetches, busy until loaded
// - Busy after second half of data write/increment-read
// - Other accesses keep ready low
// - Control and address accesses never touch ready
// - Selects captured at strobe or address strobe fall
// - Read data valid two clocks before ready falls
// - Data bus driven only during read strobe
module hpp_port
  import hpp_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Host control pins
  input  wire logic              host_chip_select_n,
  input  wire logic              host_data_strobe_one,
  input  wire logic              host_data_strobe_two,
  input  wire logic              host_address_strobe_n,
  input  wire logic [1:0]        host_register_select,
  input  wire logic              host_read_write,
  input  wire logic              half_word_identifier,
  output logic                   host_ready_n,
  // Host data bus, split into three signals
  input  wire logic [HALF_W-1:0] host_data_bus_in,
  output logic [HALF_W-1:0]      host_data_bus_out,
  output logic                   host_data_bus_oe,
  // Fetch port to the internal DMA address generator
  output logic                   fetch_req,
  output logic [WORD_W-1:0]      fetch_addr,
  input  wire logic              fetch_ack,
  input  wire logic [WORD_W-1:0] fetch_data,
  // Write port to internal memory, after the FIFO
  output logic                   mem_wr_valid,
  input  wire logic              mem_wr_ready,
  output logic [WORD_W-1:0]      mem_wr_addr,
  output logic [WORD_W-1:0]      mem_wr_data,
  // Control register contents
  output logic [WORD_W-1:0]      control_value
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  hpp_stream_if #(.W(2 * WORD_W)) push_s ();
  hpp_stream_if #(.W(2 * WORD_W)) pop_s ();

  logic combined_host_strobe;
  logic strobe_r, strobe_nxt, has_r, has_nxt;
  logic strobe_fall, strobe_rise, has_fall;
  logic [1:0] asel_r, asel_nxt, sel_r, sel_nxt;
  logic arw_r, arw_nxt, rw_r, rw_nxt;
  logic ahw_r, ahw_nxt, hw_r, hw_nxt;
  logic alat_r, alat_nxt, act_r, act_nxt;
  logic [WORD_W-1:0] ctrl_r, ctrl_nxt, addr_r, addr_nxt;
  logic [WORD_W-1:0] data_r, data_nxt, wbuf_r, wbuf_nxt;
  logic [HALF_W-1:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic start_fetch, start_write, start_incr;
  logic [1:0] cap_sel;
  logic cap_rw, cap_hw;
  logic [WORD_W-1:0] rd_word;
  hpp_state_t state_r, state_nxt;
  logic [2:0] lead_r, lead_nxt;
  logic fpend_r, fpend_nxt, wpend_r, wpend_nxt, ipend_r, ipend_nxt;
  logic winc_r, winc_nxt;
  logic load_data, incr_addr, busy;

  // Picks one half of a word by the half-word identifier
  function automatic logic [HALF_W-1:0] half_of(
    input logic [WORD_W-1:0] w,
    input logic              hw
  );
    half_of = (hw == HALF_FIRST) ? w[HALF_W-1:0] : w[WORD_W-1:HALF_W];
  endfunction

  // Replaces one half of a word by the half-word identifier
  function automatic logic [WORD_W-1:0] put_half(
    input logic [WORD_W-1:0] w,
    input logic              hw,
    input logic [HALF_W-1:0] h
  );
    put_half = (hw == HALF_FIRST) ? {w[WORD_W-1:HALF_W], h} :
                                    {h, w[HALF_W-1:0]};
  endfunction

  // ****************************************************************
  // Host strobe and select capture
  // ****************************************************************
  assign combined_host_strobe = ~(host_data_strobe_one ^
                                  host_data_strobe_two)
                                | host_chip_select_n;
  assign strobe_fall = strobe_r & ~combined_host_strobe;
  assign strobe_rise = ~strobe_r & combined_host_strobe;
  assign has_fall    = has_r & ~host_address_strobe_n;
  // Address strobe copy wins when one was latched this access
  assign cap_sel = alat_r ? asel_r : host_register_select;
  assign cap_rw  = alat_r ? arw_r : host_read_write;
  assign cap_hw  = alat_r ? ahw_r : half_word_identifier;
  assign rd_word = (sel_r == SEL_CTRL) ? ctrl_r :
                   (sel_r == SEL_ADDR) ? addr_r : data_r;

  // Access decode, register updates and bus drive
  always_comb begin
    strobe_nxt  = combined_host_strobe;
    has_nxt     = host_address_strobe_n;
    asel_nxt    = asel_r;
    arw_nxt     = arw_r;
    ahw_nxt     = ahw_r;
    alat_nxt    = alat_r;
    sel_nxt     = sel_r;
    rw_nxt      = rw_r;
    hw_nxt      = hw_r;
    act_nxt     = act_r;
    ctrl_nxt    = ctrl_r;
    addr_nxt    = incr_addr ? addr_r + ADDR_STEP : addr_r;
    data_nxt    = load_data ? fetch_data : data_r;
    wbuf_nxt    = wbuf_r;
    oe_nxt      = oe_r;
    dout_nxt    = (act_r && rw_r == DIR_READ) ? half_of(rd_word, hw_r)
                                              : dout_r;
    start_fetch = 1'b0;
    start_write = 1'b0;
    start_incr  = 1'b0;
    if (has_fall) begin
      asel_nxt = host_register_select;
      arw_nxt  = host_read_write;
      ahw_nxt  = half_word_identifier;
      alat_nxt = 1'b1;
    end
    if (strobe_fall) begin
      sel_nxt  = cap_sel;
      rw_nxt   = cap_rw;
      hw_nxt   = cap_hw;
      act_nxt  = 1'b1;
      alat_nxt = 1'b0;
      oe_nxt   = (cap_rw == DIR_READ);
      start_fetch = (cap_rw == DIR_READ) && cap_sel[1] &&
                    (cap_hw == HALF_FIRST);
    end
    if (strobe_rise && act_r) begin
      act_nxt = 1'b0;
      oe_nxt  = 1'b0;
      if (rw_r != DIR_READ) begin
        unique case (sel_r)
          SEL_CTRL: ctrl_nxt = put_half(ctrl_r, hw_r,
                                        host_data_bus_in);
          SEL_ADDR: addr_nxt = put_half(addr_r, hw_r,
                                        host_data_bus_in);
          SEL_DATA_INC,
          SEL_DATA_FIX: begin
            wbuf_nxt    = put_half(wbuf_r, hw_r, host_data_bus_in);
            start_write = (hw_r != HALF_FIRST);
          end
        endcase
      end else if (sel_r == SEL_DATA_INC && hw_r != HALF_FIRST) begin
        start_incr = 1'b1;
      end
    end
  end

  // Register host-side state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strobe_r <= 1'b1;
      has_r    <= 1'b1;
      asel_r   <= SEL_CTRL;
      arw_r    <= DIR_READ;
      ahw_r    <= HALF_FIRST;
      alat_r   <= 1'b0;
      sel_r    <= SEL_CTRL;
      rw_r     <= DIR_READ;
      hw_r     <= HALF_FIRST;
      act_r    <= 1'b0;
      ctrl_r   <= CTRL_RESET;
      addr_r   <= ADDR_RESET;
      data_r   <= DATA_RESET;
      wbuf_r   <= DATA_RESET;
      dout_r   <= '0;
      oe_r     <= 1'b0;
    end else begin
      strobe_r <= strobe_nxt;
      has_r    <= has_nxt;
      asel_r   <= asel_nxt;
      arw_r    <= arw_nxt;
      ahw_r    <= ahw_nxt;
      alat_r   <= alat_nxt;
      sel_r    <= sel_nxt;
      rw_r     <= rw_nxt;
      hw_r     <= hw_nxt;
      act_r    <= act_nxt;
      ctrl_r   <= ctrl_nxt;
      addr_r   <= addr_nxt;
      data_r   <= data_nxt;
      wbuf_r   <= wbuf_nxt;
      dout_r   <= dout_nxt;
      oe_r     <= oe_nxt;
    end
  end

  // ****************************************************************
  // Internal completion sequencer
  // ****************************************************************
  assign load_data = (state_r == ST_FETCH) && fetch_ack;
  assign incr_addr = (state_r == ST_FINISH) &&
                     ((wpend_r && push_s.ready && winc_r) ||
                      (!wpend_r && ipend_r));
  assign busy = (state_r != ST_IDLE) | fpend_r | wpend_r | ipend_r;

  // Pending flags (set wins over clear) and state transitions
  always_comb begin
    state_nxt = state_r;
    lead_nxt  = lead_r;
    fpend_nxt = fpend_r;
    wpend_nxt = wpend_r;
    ipend_nxt = ipend_r;
    winc_nxt  = winc_r;
    unique case (state_r)
      ST_IDLE: begin
        if (fpend_r) begin
          state_nxt = ST_FETCH;
          fpend_nxt = 1'b0;
        end else if (wpend_r || ipend_r) begin
          state_nxt = ST_FINISH;
        end
      end
      ST_FETCH: begin
        if (fetch_ack) begin
          state_nxt = ST_LEAD;
          lead_nxt  = '0;
        end
      end
      ST_LEAD: begin
        lead_nxt = lead_r + 1'b1;
        if (lead_r == LEAD_LAST) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FINISH: begin
        if (wpend_r) begin
          if (push_s.ready) begin
            wpend_nxt = 1'b0;
          end
        end else begin
          ipend_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
    endcase
    if (start_fetch) begin
      fpend_nxt = 1'b1;
    end
    if (start_write) begin
      wpend_nxt = 1'b1;
      winc_nxt  = (sel_r == SEL_DATA_INC);
    end
    if (start_incr) begin
      ipend_nxt = 1'b1;
    end
  end

  // Register sequencer state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      lead_r  <= '0;
      fpend_r <= 1'b0;
      wpend_r <= 1'b0;
      ipend_r <= 1'b0;
      winc_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lead_r  <= lead_nxt;
      fpend_r <= fpend_nxt;
      wpend_r <= wpend_nxt;
      ipend_r <= ipend_nxt;
      winc_r  <= winc_nxt;
    end
  end

  // ****************************************************************
  // Outputs and write FIFO
  // ****************************************************************
  // Busy shows only while selected; idle or other accesses read low
  assign host_ready_n = ~host_chip_select_n & busy;
  assign host_data_bus_out = dout_r;
  assign host_data_bus_oe  = oe_r & ~combined_host_strobe;
  assign fetch_req     = (state_r == ST_FETCH);
  assign fetch_addr    = addr_r;
  assign control_value = ctrl_r;
  assign push_s.valid  = (state_r == ST_FINISH) & wpend_r;
  assign push_s.data   = {addr_r, wbuf_r};
  assign mem_wr_valid  = pop_s.valid;
  assign mem_wr_addr   = pop_s.data[2*WORD_W-1:WORD_W];
  assign mem_wr_data   = pop_s.data[WORD_W-1:0];
  assign pop_s.ready   = mem_wr_ready;

  hpp_fifo #(
    .W     (2 * WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .in_s    (push_s),
    .out_s   (pop_s)
  );

endmodule
`default_nettype wire

// File: test/hpp_port_checker.sv
// Concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none
module hpp_port_checker
  import hpp_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // Host pins
  input wire logic              host_chip_select_n,
  input wire logic              host_data_strobe_one,
  input wire logic              host_data_strobe_two,
  input wire logic [1:0]        host_register_select,
  input wire logic              host_read_write,
  input wire logic              half_word_identifier,
  input wire logic              host_ready_n,
  input wire logic [HALF_W-1:0] host_data_bus_out,
  input wire logic              host_data_bus_oe,
  // Fetch port
  input wire logic              fetch_req,
  input wire logic              fetch_ack
);
  // ****
  // Combined strobe and access kinds
  // ****
  wire logic strobe_n;
  assign strobe_n = ~(host_data_strobe_one ^ host_data_strobe_two)
                    | host_chip_select_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_rd_first;
    $fell(strobe_n) && host_register_select[1] &&
    host_read_write == DIR_READ && half_word_identifier == HALF_FIRST;
  endsequence
  sequence s_end_second;
    $rose(strobe_n) && !host_chip_select_n && host_register_select[1] &&
    half_word_identifier != HALF_FIRST &&
    (host_read_write != DIR_READ || host_register_select == SEL_DATA_INC);
  endsequence
  a_ready_cs_gate: assert property (
    host_chip_select_n |-> !host_ready_n)
    else $error("ready high while chip select high");
  a_oe_in_strobe: assert property (
    host_data_bus_oe |-> !strobe_n && host_read_write == DIR_READ)
    else $error("data bus driven outside a read strobe");
  a_read_drives: assert property (
    $fell(strobe_n) && host_read_write == DIR_READ |=> host_data_bus_oe)
    else $error("read strobe did not drive the bus");
  a_write_no_drive: assert property (
    $fell(strobe_n) && host_read_write != DIR_READ |=> !host_data_bus_oe)
    else $error("bus driven during a write");
  a_read_fetch: assert property (
    s_rd_first |=> host_ready_n ##1 fetch_req)
    else $error("data read did not fetch while busy");
  a_req_held: assert property (
    fetch_req && !fetch_ack |=> fetch_req)
    else $error("fetch request dropped before ack");
  a_busy_fetch: assert property (
    fetch_req |-> host_ready_n || host_chip_select_n)
    else $error("ready low while fetch outstanding");
  a_data_lead: assert property (
    $fell(host_ready_n) && host_data_bus_oe
      |-> host_data_bus_out == $past(host_data_bus_out, 2))
    else $error("read data not settled two clocks before ready");
  a_write_busy: assert property (
    s_end_second |=> host_ready_n || host_chip_select_n)
    else $error("no busy after second half");
  a_quiet_regs: assert property (
    $fell(strobe_n) && !host_register_select[1] && !host_ready_n
      |=> !host_ready_n [*4])
    else $error("register access touched ready");
endmodule
bind hpp_port hpp_port_checker u_chk (
  .clk_sys(clk_sys), .rst(rst),
  .host_chip_select_n(host_chip_select_n),
  .host_data_strobe_one(host_data_strobe_one),
  .host_data_strobe_two(host_data_strobe_two),
  .host_register_select(host_register_select),
  .host_read_write(host_read_write),
  .half_word_identifier(half_word_identifier),
  .host_ready_n(host_ready_n), .host_data_bus_out(host_data_bus_out),
  .host_data_bus_oe(host_data_bus_oe),
  .fetch_req(fetch_req), .fetch_ack(fetch_ack)
);
`default_nettype wire

// File: test/hpp_host_model.sv
// Host processor driving the parallel port, one half-word per call
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model
  import hpp_pkg::*;
(
  // Clock and device answers
  input  wire logic              clk_sys,
  input  wire logic              host_ready_n,
  input  wire logic [HALF_W-1:0] host_data_bus_out,
  // Pins toward the device
  output logic                   host_chip_select_n,
  output logic                   host_data_strobe_one,
  output logic                   host_data_strobe_two,
  output logic                   host_address_strobe_n,
  output logic [1:0]             host_register_select,
  output logic                   host_read_write,
  output logic                   half_word_identifier,
  output logic [HALF_W-1:0]      host_data_bus_in
);
  int n_late = 0;  // Waits that ran out
  initial begin
    host_chip_select_n    = 1'b1;
    host_data_strobe_one  = 1'b1;
    host_data_strobe_two  = 1'b1;
    host_address_strobe_n = 1'b1;
    host_register_select  = 2'h0;
    host_read_write       = DIR_READ;
    half_word_identifier  = HALF_FIRST;
    host_data_bus_in      = 16'h0000;
  end
  // Bounded wait for ready low
  task automatic wait_ready();
    int k;
    k = 0;
    while (host_ready_n !== 1'b0 && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 300) n_late++;
  endtask
  // One half-word transfer; ua uses the address strobe
  task automatic half(input logic [1:0] sel, input logic rw,
                      input logic hw, input logic [HALF_W-1:0] din,
                      input bit ua, output logic [HALF_W-1:0] rd);
    @(negedge clk_sys);
    host_register_select = sel;
    host_read_write      = rw;
    half_word_identifier = hw;
    host_chip_select_n   = 1'b0;
    if (rw != DIR_READ) host_data_bus_in = din;
    @(negedge clk_sys);
    wait_ready();
    host_address_strobe_n = !ua;
    @(negedge clk_sys);
    host_data_strobe_one = 1'b0;  // Strobes differ: strobe low
    repeat ($urandom_range(4, 7)) @(negedge clk_sys);
    host_address_strobe_n = 1'b1;
    wait_ready();
    rd = host_data_bus_out;
    host_data_strobe_one = 1'b1;
    repeat (4) @(negedge clk_sys);
    host_data_bus_in = ~host_data_bus_in;  // Released, no stale value
  endtask
  // Chip select alone, data strobes left idle
  task automatic select(input logic en_n);
    host_chip_select_n = en_n;
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench of the host parallel port handshake
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hpp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              cs_n, ds1, ds2, as_n, rw, hw, ready_n, oe, stall;
  logic [1:0]        sel;
  logic [HALF_W-1:0] din, dout;
  logic              fetch_req, mem_wr_valid;
  logic              fetch_ack = 1'b0;
  logic              mem_wr_ready = 1'b0;
  logic [WORD_W-1:0] fetch_data = 32'h0000_0000;
  logic [WORD_W-1:0] fetch_addr, mem_wr_addr, mem_wr_data, ctrl;
  logic [31:0]       exp_q[$];  // Expected writes: address, data
  int                n_errors = 0;
  int                total_checks = 0;
  always #25 clk_sys = ~clk_sys;
  hpp_port #(.FIFO_DEPTH(4)) dut (
    .clk_sys(clk_sys), .rst(rst), .host_chip_select_n(cs_n),
    .host_data_strobe_one(ds1), .host_data_strobe_two(ds2),
    .host_address_strobe_n(as_n), .host_register_select(sel),
    .host_read_write(rw), .half_word_identifier(hw),
    .host_ready_n(ready_n), .host_data_bus_in(din),
    .host_data_bus_out(dout), .host_data_bus_oe(oe),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .control_value(ctrl));
  hpp_host_model host (
    .clk_sys(clk_sys), .host_ready_n(ready_n), .host_data_bus_out(dout),
    .host_chip_select_n(cs_n), .host_data_strobe_one(ds1),
    .host_data_strobe_two(ds2), .host_address_strobe_n(as_n),
    .host_register_select(sel), .host_read_write(rw),
    .half_word_identifier(hw), .host_data_bus_in(din));
  // ****
  // Checking helpers
  // ****
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[15:0] ^ 16'h3c5a, a[31:16] ^ 16'h96e1};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic word(input logic [1:0] s, input logic d,
                      input logic [31:0] w, input bit ua,
                      output logic [31:0] r);
    host.half(s, d, HALF_FIRST, w[15:0], ua, r[15:0]);
    host.half(s, d, !HALF_FIRST, w[31:16], ua, r[31:16]);
  endtask
  // Fetch unit: answers after a random delay, noise otherwise
  always @(negedge clk_sys) begin
    fetch_ack <= 1'b0;
    if (fetch_req && !fetch_ack && $urandom_range(0, 3) == 0) begin
      fetch_ack  <= 1'b1;
      fetch_data <= mem_word(fetch_addr);
    end else fetch_data <= ~fetch_data;
  end
  // Memory sink: picks ready, checks the word the next edge accepts
  always @(negedge clk_sys) begin
    logic rdy;
    rdy = stall ? 1'b0 : 1'($urandom_range(0, 1));
    if (mem_wr_valid && rdy) begin
      chk("mem_addr", mem_wr_addr, exp_q.pop_front());
      chk("mem_data", mem_wr_data, exp_q.pop_front());
    end
    mem_wr_ready <= rdy;
  end
  initial begin
    #3_000_000;
    n_errors++;
    end_sim();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] a, w, r;
    int k;
    stall = 1'b0;
    void'($urandom(32'h6dc32c36));
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    chk("reset_outs", 32'({ready_n, oe, fetch_req, mem_wr_valid}), 0);
    chk("ctrl_reset", ctrl, CTRL_RESET);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      w = $urandom;
      word(SEL_CTRL, !DIR_READ, w, i[0], r);
      chk("ctrl_value", ctrl, w);
      word(SEL_CTRL, DIR_READ, 0, !i[0], r);
      chk("ctrl_read", r, w);
    end
    a = $urandom & 32'hffff_fffc;
    word(SEL_ADDR, !DIR_READ, a, 1'b1, r);
    word(SEL_ADDR, DIR_READ, 0, 1'b0, r);
    chk("addr_read", r, a);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      word(SEL_DATA_FIX, DIR_READ, 0, i[0], r);
      chk("fix_read", r, mem_word(a));
    end
    $display("test fixed read done");
    for (int i = 0; i < 5; i++) begin
      w = $urandom;
      exp_q.push_back(a);
      exp_q.push_back(w);
      word(i < 4 ? SEL_DATA_INC : SEL_DATA_FIX, !DIR_READ, w, i[0], r);
      if (i < 4) a += ADDR_STEP;
    end
    for (int i = 0; i < 2; i++) begin
      word(SEL_DATA_INC, DIR_READ, 0, i[0], r);
      chk("inc_read", r, mem_word(a));
      a += ADDR_STEP;
    end
    $display("test writes and increment reads done");
    stall = 1'b1;
    for (int i = 0; i < 6; i++) begin
      w = $urandom;
      exp_q.push_back(a + ADDR_STEP * i);
      exp_q.push_back(w);
      word(SEL_DATA_INC, !DIR_READ, w, 1'b0, r);
    end
    @(negedge clk_sys);
    host.select(1'b1);
    @(negedge clk_sys);
    chk("ready_cs_high", 32'(ready_n), 0);
    host.select(1'b0);
    @(negedge clk_sys);
    chk("ready_cs_fall", 32'(ready_n), 1);
    stall = 1'b0;
    host.wait_ready();
    k = 0;
    while (exp_q.size() != 0 && k < 500) begin
      @(negedge clk_sys);
      k++;
    end
    chk("fifo_drained", exp_q.size(), 0);
    chk("host_waits", host.n_late, 0);
    $display("test fill and drain done");
    end_sim();
  end
endmodule
`default_nettype wire
